/* hdl/acdp_pkg.sv */
package acdp_pkg;

	// ---------------------------------------------------------------
	// Auxiliary control register layout
	// ---------------------------------------------------------------
	localparam int unsigned ACDP_SEL_POS = 0;
	localparam int unsigned ACDP_ZERO_POS = 2;
	localparam int unsigned ACDP_SOFTWARE_RESET_BIT_POS = 3;
	localparam logic [7:0] ACDP_AUX_RESET = 8'h00;
	localparam logic [7:0] ACDP_AUX_WMASK = 8'hFB;
	localparam logic [15:0] ACDP_PTR_RESET = 16'h0000;
	localparam logic [15:0] ACDP_RESTART_ADDR = 16'h0000;

	// ---------------------------------------------------------------
	// Pointer operations issued by the execution unit
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ACDP_OP_NONE,
		ACDP_OP_INC,
		ACDP_OP_LOAD,
		ACDP_OP_WR_HI,
		ACDP_OP_WR_LO
	} acdp_op_t;

	// ---------------------------------------------------------------
	// Reset pulse length in system clocks
	// ---------------------------------------------------------------
	localparam int unsigned ACDP_SOFTWARE_RESET_BIT_CYCLES = 2;

endpackage : acdp_pkg

/* hdl/acdp_pointer_bank.sv */
`timescale 1ns/10ps
`default_nettype none
module acdp_pointer_bank #(
	parameter int unsigned W = 16
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic sync_clr,
	input wire logic sel,
	input wire acdp_pkg::acdp_op_t op,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] cur_ptr,
	output logic [W-1:0] ptr0,
	output logic [W-1:0] ptr1
);

	typedef struct packed {
		logic [1:0][W-1:0] p;
	} acdp_bank_t;

	acdp_bank_t st_reg;
	acdp_bank_t st_next;

	// -------------------------------------------------------------
	// Update logic
	// -------------------------------------------------------------
	// Operations write only the selected pointer; the other holds. sync_clr clears both.
	always_comb begin
		st_next = st_reg;
		if (sync_clr) begin
			st_next.p[0] = acdp_pkg::ACDP_PTR_RESET;
			st_next.p[1] = acdp_pkg::ACDP_PTR_RESET;
		end else begin
			case (op)
				acdp_pkg::ACDP_OP_INC: st_next.p[sel] = st_reg.p[sel] + W'(1); // [RULE6]
				acdp_pkg::ACDP_OP_LOAD: st_next.p[sel] = wdata; // [RULE8]
				acdp_pkg::ACDP_OP_WR_HI: st_next.p[sel][W-1:W/2] = wdata[W/2-1:0]; // [RULE11]
				acdp_pkg::ACDP_OP_WR_LO: st_next.p[sel][W/2-1:0] = wdata[W/2-1:0]; // [RULE11]
				default: st_next = st_reg;
			endcase
		end
	end

	// State register.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	// The active pointer is the only one reachable by operations.
	assign cur_ptr = st_reg.p[sel]; // [RULE4] [RULE5]
	assign ptr0 = st_reg.p[0];
	assign ptr1 = st_reg.p[1];

endmodule : acdp_pointer_bank
`default_nettype wire

/* hdl/acdp_reset_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module acdp_reset_gen #(
	parameter int unsigned CYCLES = acdp_pkg::ACDP_SOFTWARE_RESET_BIT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic trigger,
	input wire logic ext_rst_req,
	output logic chip_rst
);

	typedef struct packed {
		logic [7:0] cnt;
	} acdp_rg_t;

	acdp_rg_t st_reg;
	acdp_rg_t st_next;

	// -------------------------------------------------------------
	// Pulse stretcher
	// -------------------------------------------------------------
	// Software and external/watchdog requests load the same counter,
	// so every source gives an identical reset pulse.
	always_comb begin
		st_next = st_reg;
		if (trigger || ext_rst_req) begin
			st_next.cnt = 8'(CYCLES); // [RULE2]
		end else if (st_reg.cnt != 8'h00) begin
			st_next.cnt = st_reg.cnt - 8'h01;
		end
	end

	// Counter register.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign chip_rst = (st_reg.cnt != 8'h00);

endmodule : acdp_reset_gen
`default_nettype wire

/* hdl/acdp_aux_control.sv */
// Functional notes
// RULE1 - Writing bit 3 resets chip, restarts at 0000.
// RULE2 - Software reset equals external or watchdog reset.
// RULE3 - Software must avoid setting reset bit accidentally.
// RULE4 - Select bit chooses one of two pointers.
// RULE5 - Unselected pointer is unreachable and holds value.
// RULE6 - Increment adds one to selected pointer only.
// RULE7 - Indexed jump target is accumulator plus pointer.
// RULE8 - Immediate load writes selected pointer only.
// RULE9 - Code read fetches byte at accumulator plus pointer.
// RULE10 - Data moves address memory with selected pointer.
// RULE11 - High and low byte access selected pointer.
// RULE12 - Data moves reach on-chip configuration storage.
// RULE13 - Bit 2 reads zero, ignores writes.
// RULE14 - Select bit is bit 0, cleared by reset.
`timescale 1ns/10ps
`default_nettype none
module acdp_aux_control #(
	parameter int unsigned PTR_W = 16,
	parameter int unsigned DATA_W = 8
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic ext_rst_req,
	input wire logic aux_wr,
	input wire logic [DATA_W-1:0] aux_wdata,
	output logic [DATA_W-1:0] aux_rdata,
	input wire acdp_pkg::acdp_op_t ptr_op,
	input wire logic [PTR_W-1:0] ptr_wdata,
	input wire logic [DATA_W-1:0] acc,
	output logic [DATA_W-1:0] ptr_high_byte,
	output logic [DATA_W-1:0] ptr_low_byte,
	output logic [PTR_W-1:0] jump_target,
	output logic [PTR_W-1:0] code_read_addr,
	input wire logic [DATA_W-1:0] code_rdata,
	output logic [DATA_W-1:0] code_read_result,
	output logic [PTR_W-1:0] data_move_addr,
	output logic chip_rst,
	output logic [PTR_W-1:0] restart_addr
);

	typedef struct packed {
		logic [DATA_W-1:0] aux;
		logic [PTR_W-1:0] jmp;
		logic [PTR_W-1:0] caddr;
		logic [DATA_W-1:0] cres;
		logic [PTR_W-1:0] daddr;
	} acdp_top_t;

	acdp_top_t st_reg;
	acdp_top_t st_next;
	logic [PTR_W-1:0] cur_ptr;
	logic software_reset_bit_trig;
	logic pointer_select_bit;
	logic [PTR_W-1:0] ptr0_w;
	logic [PTR_W-1:0] ptr1_w;

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	// Both indexed forms share the same address adder.
	function automatic logic [PTR_W-1:0] acdp_index(input logic [DATA_W-1:0] a,
		input logic [PTR_W-1:0] p);
		acdp_index = p + PTR_W'(a);
	endfunction : acdp_index

	// -------------------------------------------------------------
	// Software reset trigger
	// -------------------------------------------------------------
	// The reset bit is not stored: the write itself fires the reset,
	// so nothing lingers that could retrigger after restart.
	assign software_reset_bit_trig = aux_wr && aux_wdata[acdp_pkg::ACDP_SOFTWARE_RESET_BIT_POS]; // [RULE1]

	acdp_reset_gen u_rst (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.trigger(software_reset_bit_trig),
		.ext_rst_req(ext_rst_req),
		.chip_rst(chip_rst)
	);

	assign pointer_select_bit = st_reg.aux[acdp_pkg::ACDP_SEL_POS]; // [RULE14]

	acdp_pointer_bank #(
		.W(PTR_W)
	) u_ptr (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.sync_clr(chip_rst),
		.sel(pointer_select_bit),
		.op(ptr_op),
		.wdata(ptr_wdata),
		.cur_ptr(cur_ptr),
		.ptr0(ptr0_w),
		.ptr1(ptr1_w)
	);

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	// Addresses are registered so data outputs come from flops; the
	// execution unit sees them one cycle after the pointer settles.
	always_comb begin
		st_next = st_reg;
		if (chip_rst) begin
			st_next.aux = acdp_pkg::ACDP_AUX_RESET; // [RULE2] [RULE14]
		end else if (aux_wr && !software_reset_bit_trig) begin
			// Bit 2 is masked so an increment carries into bit 3 never.
			st_next.aux = aux_wdata & acdp_pkg::ACDP_AUX_WMASK; // [RULE13]
			st_next.aux[acdp_pkg::ACDP_SOFTWARE_RESET_BIT_POS] = 1'b0;
		end
		st_next.jmp = acdp_index(acc, cur_ptr); // [RULE7]
		st_next.caddr = acdp_index(acc, cur_ptr); // [RULE9]
		st_next.cres = code_rdata; // [RULE9]
		st_next.daddr = cur_ptr; // [RULE10] [RULE12]
	end

	// State register.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	// -------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------
	assign aux_rdata = st_reg.aux; // [RULE13]
	assign ptr_high_byte = cur_ptr[PTR_W-1:PTR_W-DATA_W]; // [RULE11]
	assign ptr_low_byte = cur_ptr[DATA_W-1:0]; // [RULE11]
	assign jump_target = st_reg.jmp;
	assign code_read_addr = st_reg.caddr;
	assign code_read_result = st_reg.cres;
	assign data_move_addr = st_reg.daddr;
	assign restart_addr = acdp_pkg::ACDP_RESTART_ADDR; // [RULE1]

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	AST_SOFTWARE_RESET_BIT_FIRES: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE1]
		(clk_en && software_reset_bit_trig) |=> chip_rst)
		else $error("Software reset write did not assert chip reset.");

	AST_RST_CLEARS_SEL: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE14]
		(clk_en && chip_rst) |=> !pointer_select_bit)
		else $error("Reset did not clear the pointer select bit.");

	AST_EXT_RST_SAME: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE2]
		(clk_en && ext_rst_req) |=> chip_rst)
		else $error("External reset request did not reset the chip.");

	AST_BIT2_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE13]
		aux_rdata[acdp_pkg::ACDP_ZERO_POS] == 1'b0)
		else $error("Bit 2 of the control register reads nonzero.");

	AST_SEL_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE4]
		(clk_en && aux_wr && !software_reset_bit_trig && !chip_rst) |=>
		pointer_select_bit == $past(aux_wdata[acdp_pkg::ACDP_SEL_POS]))
		else $error("Select bit did not follow the written value.");

	AST_INC_SEL: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE6]
		(clk_en && ptr_op == acdp_pkg::ACDP_OP_INC && !chip_rst && !aux_wr) |=>
		cur_ptr == $past(cur_ptr) + PTR_W'(1))
		else $error("Increment did not add one to the selected pointer.");

	AST_LOAD_SEL: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE8]
		(clk_en && ptr_op == acdp_pkg::ACDP_OP_LOAD && !chip_rst && !aux_wr) |=>
		cur_ptr == $past(ptr_wdata))
		else $error("Load did not reach the selected pointer.");

	AST_JUMP_SUM: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE7]
		clk_en |=> jump_target == $past(cur_ptr) + PTR_W'($past(acc)))
		else $error("Jump target is not accumulator plus pointer.");

	AST_DATA_ADDR: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE10]
		clk_en |=> data_move_addr == $past(cur_ptr))
		else $error("Data move address is not the selected pointer.");

	AST_CODE_RES: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE9]
		clk_en |=> code_read_result == $past(code_rdata))
		else $error("Code read result not returned to accumulator path.");

	// -------------------------------------------------------------
	// Reset checks
	// -------------------------------------------------------------
	// The reset bit must act as a strobe only; a stored copy would
	// fire the reset again after every restart.
	AST_SOFTWARE_RESET_BIT_NOT_STORED: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE1]
		aux_rdata[acdp_pkg::ACDP_SOFTWARE_RESET_BIT_POS] == 1'b0)
		else $error("Software reset bit reads back as one.");

	AST_SOFTWARE_RESET_BIT_NO_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE1]
		(clk_en && software_reset_bit_trig && !chip_rst) |=>
		$stable(pointer_select_bit))
		else $error("Software reset write changed the select bit.");

	AST_SOFTWARE_RESET_BIT_AUX: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE1]
		(clk_en && software_reset_bit_trig) ##1 clk_en |=>
		aux_rdata == acdp_pkg::ACDP_AUX_RESET)
		else $error("Software reset did not clear the control register.");

	AST_RST_PULSE_TWO: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE2]
		(clk_en && (software_reset_bit_trig || ext_rst_req)) ##1 clk_en |=>
		chip_rst)
		else $error("Chip reset pulse ended after one cycle.");

	AST_AUX_CLEARED: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE2]
		(clk_en && chip_rst) |=>
		aux_rdata == acdp_pkg::ACDP_AUX_RESET)
		else $error("Chip reset left the control register set.");

	AST_PTRS_CLEARED: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE2]
		(clk_en && chip_rst) |=>
		(ptr0_w == acdp_pkg::ACDP_PTR_RESET && ptr1_w == acdp_pkg::ACDP_PTR_RESET))
		else $error("Chip reset left a pointer set.");

	AST_SEL_EXT: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE14]
		(clk_en && ext_rst_req) ##1 clk_en |=>
		!pointer_select_bit)
		else $error("External reset did not select the first pointer.");

	// -------------------------------------------------------------
	// Pointer isolation checks
	// -------------------------------------------------------------
	// The hidden pointer is watched directly, since the visible bytes
	// alone could never reveal a stray write to it.
	AST_UNSEL_HOLD0: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE5]
		(clk_en && !chip_rst && pointer_select_bit) |=>
		ptr0_w == $past(ptr0_w))
		else $error("First pointer changed while not selected.");

	AST_UNSEL_HOLD1: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE5]
		(clk_en && !chip_rst && !pointer_select_bit) |=>
		ptr1_w == $past(ptr1_w))
		else $error("Second pointer changed while not selected.");

	AST_NO_OP_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE5]
		(clk_en && ptr_op == acdp_pkg::ACDP_OP_NONE && !aux_wr && !chip_rst) |=>
		$stable(cur_ptr))
		else $error("Selected pointer changed with no operation.");

	AST_SEL_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE4]
		(clk_en && !aux_wr && !chip_rst) |=>
		$stable(pointer_select_bit))
		else $error("Select bit changed without a register write.");

	AST_WR_HI: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE11]
		(clk_en && ptr_op == acdp_pkg::ACDP_OP_WR_HI && !chip_rst && !aux_wr) |=>
		(ptr_high_byte == $past(ptr_wdata[DATA_W-1:0]) && $stable(ptr_low_byte)))
		else $error("High byte write missed the selected pointer.");

	AST_WR_LO: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE11]
		(clk_en && ptr_op == acdp_pkg::ACDP_OP_WR_LO && !chip_rst && !aux_wr) |=>
		(ptr_low_byte == $past(ptr_wdata[DATA_W-1:0]) && $stable(ptr_high_byte)))
		else $error("Low byte write missed the selected pointer.");

	AST_CODE_ADDR: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE9]
		clk_en |=>
		code_read_addr == $past(cur_ptr) + PTR_W'($past(acc)))
		else $error("Code read address is not accumulator plus pointer.");

	// -------------------------------------------------------------
	// Control register checks
	// -------------------------------------------------------------
	// Incrementing the register must always flip the select bit; the
	// fixed zero in bit 2 absorbs the carry out of the low bits.
	AST_INC_TOGGLE: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE13]
		(clk_en && aux_wr && !chip_rst && aux_wdata == aux_rdata + DATA_W'(1)) |=>
		pointer_select_bit != $past(pointer_select_bit))
		else $error("Register increment did not toggle the select bit.");

	AST_OTHER_BITS: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE13]
		(clk_en && aux_wr && !software_reset_bit_trig && !chip_rst) |=>
		aux_rdata == ($past(aux_wdata) & acdp_pkg::ACDP_AUX_WMASK))
		else $error("Control register bits did not follow the write.");

	// -------------------------------------------------------------
	// Clock enable checks
	// -------------------------------------------------------------
	// A low enable must stall the block completely, or the execution
	// unit would lose or repeat operations issued during a wait.
	AST_FREEZE_PTR: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE5]
		!clk_en |=>
		($stable(ptr0_w) && $stable(ptr1_w) && $stable(aux_rdata)))
		else $error("State changed while the clock enable was low.");

	AST_FREEZE_RST: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE2]
		!clk_en |=>
		$stable(chip_rst))
		else $error("Chip reset moved while the clock enable was low.");

	AST_FREEZE_OUT: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE7]
		!clk_en |=>
		($stable(jump_target) && $stable(code_read_result) && $stable(data_move_addr)))
		else $error("Outputs changed while the clock enable was low.");

endmodule : acdp_aux_control
`default_nettype wire

/* test/acdp_code_rom.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Code and configuration storage behind the execution unit
// ---------------------------------------------------------------
module acdp_code_rom (
	input wire logic [15:0] addr,
	output logic [7:0] data
);
	// Both address halves feed the byte, so a wrong high half is seen.
	assign data = addr[15:8] ^ addr[7:0] ^ 8'h5A;
endmodule : acdp_code_rom
`default_nettype wire

/* test/aux_control_dual_pointer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module aux_control_dual_pointer_tb;
	typedef struct packed {logic [7:0] aux; logic [7:0] res; logic [15:0] ptr; logic [15:0] jmp;} acdp_exp_t;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic ext_rst_req = 1'b0;
	logic aux_wr = 1'b0;
	logic [7:0] aux_wdata = 8'h00;
	acdp_pkg::acdp_op_t ptr_op = acdp_pkg::ACDP_OP_NONE;
	logic [15:0] ptr_wdata = 16'h0000;
	logic [7:0] acc = 8'h00;
	logic [7:0] aux_rdata, ptr_high_byte, ptr_low_byte, code_rdata, code_read_result;
	logic [15:0] jump_target, code_read_addr, data_move_addr, restart_addr;
	logic chip_rst;
	logic [15:0] p [2];
	logic [7:0] aux_m;
	logic [31:0] seed = 32'h0000002C;
	int errors = 0;
	int total_checks = 0;
	acdp_exp_t q[$];
	event chk_ev;

	// ---------------------------------------------------------------
	// Design and storage model
	// ---------------------------------------------------------------
	// The enable is driven so the freeze scenario can stall the block.
	acdp_aux_control DUT (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
		.ext_rst_req(ext_rst_req), .aux_wr(aux_wr), .aux_wdata(aux_wdata),
		.aux_rdata(aux_rdata), .ptr_op(ptr_op), .ptr_wdata(ptr_wdata), .acc(acc),
		.ptr_high_byte(ptr_high_byte), .ptr_low_byte(ptr_low_byte),
		.jump_target(jump_target), .code_read_addr(code_read_addr),
		.code_rdata(code_rdata), .code_read_result(code_read_result),
		.data_move_addr(data_move_addr), .chip_rst(chip_rst), .restart_addr(restart_addr));
	acdp_code_rom rom (.addr(code_read_addr), .data(code_rdata));

	// Free running clock at 40 MHz.
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : next_rand

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	// Three edges let pointer, jump and code read outputs all settle.
	task automatic settle();
		acdp_exp_t e;
		repeat (3) @(negedge clk_sys);
		e.aux = aux_m;
		e.ptr = p[aux_m[0]];
		e.jmp = {8'h00, acc} + e.ptr;
		e.res = e.jmp[15:8] ^ e.jmp[7:0] ^ 8'h5A;
		q.push_back(e);
		-> chk_ev;
	endtask : settle

	task automatic op(input acdp_pkg::acdp_op_t o, input logic [15:0] wd);
		ptr_op = o;
		ptr_wdata = wd;
		acc = 8'(next_rand());
		@(negedge clk_sys);
		ptr_op = acdp_pkg::ACDP_OP_NONE;
		case (o)
			acdp_pkg::ACDP_OP_INC: p[aux_m[0]] = p[aux_m[0]] + 16'h0001;
			acdp_pkg::ACDP_OP_LOAD: p[aux_m[0]] = wd;
			acdp_pkg::ACDP_OP_WR_HI: p[aux_m[0]][15:8] = wd[7:0];
			acdp_pkg::ACDP_OP_WR_LO: p[aux_m[0]][7:0] = wd[7:0];
			default: ;
		endcase
		settle();
	endtask : op

	// Ordinary writes keep bit 3 clear so no reset fires by accident.
	task automatic wr_aux(input logic [7:0] d);
		aux_wr = 1'b1;
		aux_wdata = d & 8'hF7;
		@(negedge clk_sys);
		aux_wr = 1'b0;
		aux_m = d & 8'hF3;
		settle();
	endtask : wr_aux

	task automatic do_rst(input logic sw);
		int n;
		n = 0;
		aux_wr = sw;
		aux_wdata = 8'h08;
		ext_rst_req = ~sw;
		@(negedge clk_sys);
		aux_wr = 1'b0;
		ext_rst_req = 1'b0;
		repeat (5) begin
			if (chip_rst === 1'b1) n++;
			@(negedge clk_sys);
		end
		cmp(16'(n), 16'(acdp_pkg::ACDP_SOFTWARE_RESET_BIT_CYCLES));
		cmp(restart_addr, 16'h0000);
		p[0] = 16'h0000;
		p[1] = 16'h0000;
		aux_m = 8'h00;
		settle();
	endtask : do_rst

	// A held increment and select write while frozen must change nothing,
	// both during the stall and after the enable returns.
	task automatic freeze_chk();
		clk_en = 1'b0;
		ptr_op = acdp_pkg::ACDP_OP_INC;
		aux_wr = 1'b1;
		aux_wdata = aux_m ^ 8'h01;
		settle();
		ptr_op = acdp_pkg::ACDP_OP_NONE;
		aux_wr = 1'b0;
		clk_en = 1'b1;
		settle();
	endtask : freeze_chk

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	// ---------------------------------------------------------------
	// Output watcher
	// ---------------------------------------------------------------
	initial begin : watch
		acdp_exp_t e;
		forever begin
			@(chk_ev);
			e = q.pop_front();
			cmp({8'h00, aux_rdata}, {8'h00, e.aux});
			cmp({ptr_high_byte, ptr_low_byte}, e.ptr);
			cmp(data_move_addr, e.ptr);
			cmp(jump_target, e.jmp);
			cmp(code_read_addr, e.jmp);
			cmp({8'h00, code_read_result}, {8'h00, e.res});
		end
	end

	// A hang is cut short well beyond the expected run of a few microseconds.
	initial begin
		#20000;
		errors++;
		wrap_up();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		p[0] = 16'h0000;
		p[1] = 16'h0000;
		aux_m = 8'h00;
		repeat (5) @(negedge clk_sys);
		arst_n = 1'b1;
		settle();
		$display("test reset done");
		op(acdp_pkg::ACDP_OP_LOAD, 16'(next_rand()));
		wr_aux(8'h01);
		op(acdp_pkg::ACDP_OP_LOAD, 16'h00FF);
		op(acdp_pkg::ACDP_OP_INC, 16'(next_rand()));
		op(acdp_pkg::ACDP_OP_WR_HI, 16'(next_rand()));
		op(acdp_pkg::ACDP_OP_WR_LO, 16'(next_rand()));
		$display("test pointer ops done");
		wr_aux(8'hF7);
		wr_aux(aux_m + 8'h01);
		op(acdp_pkg::ACDP_OP_INC, 16'h0000);
		$display("test select toggle done");
		do_rst(1'b1);
		wr_aux(8'h01);
		op(acdp_pkg::ACDP_OP_LOAD, 16'(next_rand()));
		do_rst(1'b0);
		wr_aux(8'h01);
		$display("test resets done");
		op(acdp_pkg::ACDP_OP_LOAD, 16'(next_rand()));
		freeze_chk();
		// Let the watcher compare before the async reset moves the outputs.
		@(negedge clk_sys);
		arst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		arst_n = 1'b1;
		p[0] = 16'h0000;
		p[1] = 16'h0000;
		aux_m = 8'h00;
		settle();
		wr_aux(8'h01);
		$display("test freeze and async reset done");
		// One more edge lets the watcher finish the last comparison.
		@(negedge clk_sys);
		wrap_up();
	end
endmodule : aux_control_dual_pointer_tb
`default_nettype wire
